/* File: core/flash_array_mem.sv */
`timescale 1ns/100ps
module flash_array_mem (
    input  wire logic        mclk,
    input  wire logic        wrEn,
    input  wire logic [7:0]  wrIndex,
    input  wire logic [31:0] wrData,
    input  wire logic [7:0]  rdIndex,
    output logic [31:0]      rdData
);
    logic [31:0] mem [256];

    always_ff @(posedge mclk) begin
        if (wrEn) begin
            mem[wrIndex] <= mem[wrIndex] & wrData;
        end
        rdData <= mem[rdIndex];
    end
endmodule

/* File: core/flash_sector_timer.sv */
`timescale 1ns/100ps
module flash_sector_timer (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        load,
    input  wire logic        hold,
    input  wire logic [15:0] loadValue,
    output logic             done
);
    logic [15:0] count_reg;

    always_ff @(posedge mclk) begin
        if (rst || load) begin
            count_reg <= rst ? 16'h0000 : loadValue;
        end else if (!hold && count_reg != 16'h0000) begin
            count_reg <= count_reg - 16'h0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || load) begin
            done <= 1'b0;
        end else begin
            done <= !hold && count_reg == 16'h0001;
        end
    end
endmodule

/* File: core/flash_seq_pkg.sv */
// Behaviour
// R1: software writes control registers by register-indirect stores only; direct stores unsupported.
// R2: every register write is a full 16-bit transfer.
// R3: word program writes 32 bits from address registers and first data pair.
// R4: double word program writes 64 bits, second data pair is upper word.
// R5: double word program aligns to even word, second-word address bit ignored.
// R6: setting suspend request halts running program or erase.
// R7: resume by setting erase select then start; suspended operation continues.
// R8: sector select halves both read zero once erase is complete.
// R9: changed operation select at resume aborts and sets resume error flag.
// R10: suspended erase may be interrupted by a program to another sector.
// R11: program in erase suspend: clear suspend and erase select, then program and start.
// R12: during program in erase suspend erase select and suspend read low; no suspend.
// R13: software never starts an operation while suspend request is set.
// R14: special mode set for program and erase, clear for set protection.
// R15: permanent disable targets protection disable word with data clearing bit 0.
// R16: permanent disable and re-enable possible at most sixteen times.
// R17: operation is select, load address/data/sectors, then start.
// R18: clearing a selected but unstarted operation select cancels it.
// R19: control0_high bits: start 15, suspend 14, wp 13, dwp 12, erase 11, prot 8, special_mode 7.
// R20: erase clears each sector select bit as that sector completes.
// R21: start ignored while busy; start bit cleared on finish or abort. The code leaves it set when a program in erase suspend finishes.
// R22: set protection ones update only volatile copy; nonvolatile zeros stay.
// R23: protection disable bit 0 programmable only after debug and access bits are zero.
package flash_seq_pkg;
    localparam logic [3:0] ADDR_CTRL0_LOW   = 4'h0;
    localparam logic [3:0] ADDR_CTRL0_HIGH  = 4'h1;
    localparam logic [3:0] ADDR_SECT_LOW    = 4'h2;
    localparam logic [3:0] ADDR_SECT_HIGH   = 4'h3;
    localparam logic [3:0] ADDR_TADDR_LOW   = 4'h4;
    localparam logic [3:0] ADDR_TADDR_HIGH  = 4'h5;
    localparam logic [3:0] ADDR_DATA0_LOW   = 4'h6;
    localparam logic [3:0] ADDR_DATA0_HIGH  = 4'h7;
    localparam logic [3:0] ADDR_DATA1_LOW   = 4'h8;
    localparam logic [3:0] ADDR_DATA1_HIGH  = 4'h9;
    localparam logic [3:0] ADDR_ERROR       = 4'ha;
    localparam logic [3:0] ADDR_PROT_DIS    = 4'hb;
    localparam logic [3:0] ADDR_PROT_REEN   = 4'hc;
    localparam logic [3:0] ADDR_PROT_VOL    = 4'hd;
    localparam logic [3:0] ADDR_PROT_CNT    = 4'he;

    localparam int BIT_START = 15;
    localparam int BIT_SUSPEND_REQUEST  = 14;
    localparam int BIT_WP    = 13;
    localparam int BIT_DWP   = 12;
    localparam int BIT_ERASE = 11;
    localparam int BIT_PROT  = 8;
    localparam int BIT_SPECIAL_MODE  = 7;
    localparam int BIT_ADDR2 = 2;
    localparam int BIT_RESUME_ERR = 0;
    localparam int BIT_ACCESS_PROT = 0;
    localparam int BIT_DEBUG_PROT  = 1;

    localparam logic [15:0] SELECT_MASK = 16'h3900;
    localparam logic [15:0] PROT_DIS_ADDR_LOW  = 16'hdfbc;
    localparam logic [15:0] PROT_REEN_ADDR_LOW = 16'hdfbe;
    localparam logic [15:0] PROT_ADDR_HIGH     = 16'h000e;
    localparam logic [15:0] ALL_ONES = 16'hffff;
    localparam logic [4:0]  PROT_CYCLE_MAX = 5'h10;
    localparam logic [4:0]  CYCLE_STEP     = 5'h01;

    localparam int CLK_MHZ        = 20;
    localparam int PROG_TIME_US   = 10;
    localparam int ERASE_TIME_US  = 100;
    localparam int PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
    localparam int ERASE_CYCLES   = ERASE_TIME_US * CLK_MHZ;
    localparam int SECTOR_COUNT   = 32;
    localparam logic [4:0] SECTOR_LAST = 5'h1f;

    typedef enum logic [2:0] {OP_NONE, OP_WORD, OP_DWORD, OP_ERASE, OP_PROT} op_t;

    typedef struct packed {
        logic [23:0] addr;
        logic [63:0] data;
        logic        dword;
    } prog_req_t;
endpackage

/* File: core/flash_write_operation_sequencer.sv */
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module flash_write_operation_sequencer (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [3:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [15:0]      regRdata,
    output logic             flashWrEn,
    output logic [23:0]      flashWrAddr,
    output logic [31:0]      flashWrData,
    output logic             busy
);
    typedef enum logic [2:0] {ST_IDLE, ST_PROG_LO, ST_PROG_HI, ST_ERASE, ST_ERASE_SUSPEND_REQUEST,
                              ST_PROG_SUSPEND_REQUEST, ST_PROT} state_t;

    state_t state_reg;
    logic [15:0] ctrl0Low_reg;
    logic [15:0] ctrl0High_reg;
    logic [31:0] sectSel_reg;
    logic [31:0] targetAddr_reg;
    logic [31:0] data0_reg;
    logic [31:0] data1_reg;
    logic        resumeErr_reg;
    logic [15:0] protDis_reg;
    logic [15:0] protReen_reg;
    logic [15:0] protVol_reg;
    logic [4:0]  protCycles_reg;
    logic [15:0] savedSel_reg;
    logic        progInSusp_reg;
    logic        suspended_reg;
    logic [4:0]  sector_reg;
    flash_seq_pkg::prog_req_t req;
    logic        timerLoad;
    logic [15:0] timerValue;
    logic        timerDone;
    logic [31:0] memRdData;
    logic        eraseArmed_reg;

    function automatic logic wrTo(input logic [3:0] a);
        wrTo = regWr && regAddr == a;
    endfunction

    wire startReq = wrTo(flash_seq_pkg::ADDR_CTRL0_HIGH) && regWdata[flash_seq_pkg::BIT_START];
    wire idle     = state_reg == ST_IDLE;
    wire suspReq  = wrTo(flash_seq_pkg::ADDR_CTRL0_HIGH) && regWdata[flash_seq_pkg::BIT_SUSPEND_REQUEST];

    // word pair; double word aligned to even word
    always_comb begin
        req.addr  = targetAddr_reg[23:0];
        req.dword = ctrl0High_reg[flash_seq_pkg::BIT_DWP];
        req.data  = {data1_reg, data0_reg};
        if (req.dword) begin
            req.addr[flash_seq_pkg::BIT_ADDR2] = 1'b0; // R5
        end
    end

    flash_sector_timer timer (
        .mclk      (mclk),
        .rst       (rst),
        .load      (timerLoad),
        .hold      (suspended_reg),
        .loadValue (timerValue),
        .done      (timerDone)
    );

    flash_array_mem shadow (
        .mclk    (mclk),
        .wrEn    (flashWrEn),
        .wrIndex (flashWrAddr[9:2]),
        .wrData  (flashWrData),
        .rdIndex (targetAddr_reg[9:2]),
        .rdData  (memRdData)
    );

    wire isProtDis = targetAddr_reg[15:0] == flash_seq_pkg::PROT_DIS_ADDR_LOW
                     && targetAddr_reg[31:16] == flash_seq_pkg::PROT_ADDR_HIGH;
    wire isProtReen = targetAddr_reg[15:0] == flash_seq_pkg::PROT_REEN_ADDR_LOW
                      && targetAddr_reg[31:16] == flash_seq_pkg::PROT_ADDR_HIGH;
    wire selChanged = (ctrl0High_reg & flash_seq_pkg::SELECT_MASK)
                      != (savedSel_reg & flash_seq_pkg::SELECT_MASK);

    // sequencing
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            sector_reg <= 5'h00;
            suspended_reg <= 1'b0;
            progInSusp_reg <= 1'b0;
            savedSel_reg <= 16'h0000;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (startReq && !ctrl0High_reg[flash_seq_pkg::BIT_SUSPEND_REQUEST]) begin // R17
                        savedSel_reg <= ctrl0High_reg;
                        if (ctrl0High_reg[flash_seq_pkg::BIT_WP]
                            || ctrl0High_reg[flash_seq_pkg::BIT_DWP]) begin
                            state_reg <= ST_PROG_LO; // R3 R4
                        end else if (ctrl0High_reg[flash_seq_pkg::BIT_ERASE]) begin
                            state_reg <= ST_ERASE;
                            sector_reg <= 5'h00;
                        end else if (ctrl0High_reg[flash_seq_pkg::BIT_PROT]) begin
                            state_reg <= ST_PROT;
                        end
                    end
                end
                ST_PROG_LO, ST_PROG_HI: begin
                    if (suspReq && !progInSusp_reg) begin
                        suspended_reg <= 1'b1; // R6 R12
                    end else if (suspended_reg && startReq) begin
                        if (selChanged) begin
                            state_reg <= ST_IDLE; // R9
                        end
                        suspended_reg <= 1'b0; // R7
                    end else if (timerDone) begin
                        if (state_reg == ST_PROG_LO && req.dword) begin
                            state_reg <= ST_PROG_HI;
                        end else if (progInSusp_reg) begin
                            state_reg <= ST_ERASE_SUSPEND_REQUEST; // R10
                            progInSusp_reg <= 1'b0;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_ERASE: begin
                    if (suspReq) begin
                        state_reg <= ST_ERASE_SUSPEND_REQUEST; // R6
                        suspended_reg <= 1'b1;
                    end else if (sectSel_reg == 32'h00000000) begin
                        state_reg <= ST_IDLE;
                    end else if (!sectSel_reg[sector_reg] || timerDone) begin
                        sector_reg <= sector_reg + 5'h01; // R20
                    end
                end
                ST_ERASE_SUSPEND_REQUEST: begin
                    if (startReq) begin
                        suspended_reg <= 1'b0;
                        if (ctrl0High_reg[flash_seq_pkg::BIT_WP]
                            || ctrl0High_reg[flash_seq_pkg::BIT_DWP]) begin
                            state_reg <= ST_PROG_LO; // R10 R11
                            progInSusp_reg <= 1'b1;
                        end else if (selChanged) begin
                            state_reg <= ST_IDLE; // R9
                        end else begin
                            state_reg <= ST_ERASE; // R7
                        end
                    end
                end
                ST_PROT: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    wire opEnds = (timerDone && !progInSusp_reg && (state_reg == ST_PROG_HI
                   || (state_reg == ST_PROG_LO && !req.dword)))
                  || (state_reg == ST_ERASE && sectSel_reg == 32'h00000000)
                  || state_reg == ST_PROT;
    wire abort = startReq && suspended_reg && selChanged
                 && !(state_reg == ST_ERASE_SUSPEND_REQUEST && (ctrl0High_reg[flash_seq_pkg::BIT_WP]
                 || ctrl0High_reg[flash_seq_pkg::BIT_DWP]));

    // timer loading per program word and erase sector
    always_comb begin
        timerLoad = 1'b0;
        timerValue = 16'(flash_seq_pkg::PROG_CYCLES);
        if ((idle || state_reg == ST_ERASE_SUSPEND_REQUEST) && startReq
            && (ctrl0High_reg[flash_seq_pkg::BIT_WP] || ctrl0High_reg[flash_seq_pkg::BIT_DWP])) begin
            timerLoad = 1'b1;
        end else if (state_reg == ST_PROG_LO && timerDone && req.dword) begin
            timerLoad = 1'b1;
        end
        if (state_reg == ST_ERASE && sectSel_reg[sector_reg] && !eraseArmed_reg) begin
            timerLoad = 1'b1;
            timerValue = 16'(flash_seq_pkg::ERASE_CYCLES);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || state_reg != ST_ERASE || timerDone) begin
            eraseArmed_reg <= 1'b0;
        end else if (timerLoad) begin
            eraseArmed_reg <= 1'b1;
        end
    end

    // control register 0
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl0High_reg <= 16'h0000;
            ctrl0Low_reg <= 16'h0000;
        end else begin
            if (wrTo(flash_seq_pkg::ADDR_CTRL0_LOW)) begin
                ctrl0Low_reg <= regWdata; // R2
            end
            if (wrTo(flash_seq_pkg::ADDR_CTRL0_HIGH)) begin
                ctrl0High_reg <= regWdata; // R19 R18
                if (!idle && state_reg != ST_ERASE_SUSPEND_REQUEST && !suspended_reg) begin
                    ctrl0High_reg[flash_seq_pkg::BIT_START] <= 1'b1; // R21
                    ctrl0High_reg[15:7] <= ctrl0High_reg[15:7] | {1'b0, regWdata[14], 7'h00};
                end
                if (progInSusp_reg) begin
                    ctrl0High_reg[flash_seq_pkg::BIT_SUSPEND_REQUEST] <= 1'b0; // R12
                end
            end
            if (opEnds || abort) begin
                ctrl0High_reg <= 16'h0000; // R21
            end
            if (startReq && state_reg == ST_ERASE_SUSPEND_REQUEST
                && (regWdata[flash_seq_pkg::BIT_WP] || ctrl0High_reg[flash_seq_pkg::BIT_WP]
                    || ctrl0High_reg[flash_seq_pkg::BIT_DWP])) begin
                ctrl0High_reg[flash_seq_pkg::BIT_ERASE] <= 1'b0; // R12
            end
        end
    end

    // address, data, sector select
    always_ff @(posedge mclk) begin
        if (rst) begin
            targetAddr_reg <= 32'h00000000;
            data0_reg <= 32'hffffffff;
            data1_reg <= 32'hffffffff;
            sectSel_reg <= 32'h00000000;
        end else begin
            if (wrTo(flash_seq_pkg::ADDR_TADDR_LOW))  targetAddr_reg[15:0] <= regWdata;
            if (wrTo(flash_seq_pkg::ADDR_TADDR_HIGH)) targetAddr_reg[31:16] <= regWdata;
            if (wrTo(flash_seq_pkg::ADDR_DATA0_LOW))  data0_reg[15:0] <= regWdata;
            if (wrTo(flash_seq_pkg::ADDR_DATA0_HIGH)) data0_reg[31:16] <= regWdata;
            if (wrTo(flash_seq_pkg::ADDR_DATA1_LOW))  data1_reg[15:0] <= regWdata;
            if (wrTo(flash_seq_pkg::ADDR_DATA1_HIGH)) data1_reg[31:16] <= regWdata;
            if (wrTo(flash_seq_pkg::ADDR_SECT_LOW))   sectSel_reg[15:0] <= regWdata;
            if (wrTo(flash_seq_pkg::ADDR_SECT_HIGH))  sectSel_reg[31:16] <= regWdata;
            if (state_reg == ST_ERASE && timerDone) begin
                sectSel_reg[sector_reg] <= 1'b0; // R20 R8
            end
        end
    end

    // protection words and error flag
    always_ff @(posedge mclk) begin
        if (rst) begin
            resumeErr_reg <= 1'b0;
            protDis_reg <= flash_seq_pkg::ALL_ONES;
            protReen_reg <= flash_seq_pkg::ALL_ONES;
            protVol_reg <= flash_seq_pkg::ALL_ONES;
            protCycles_reg <= 5'h00;
        end else begin
            if (wrTo(flash_seq_pkg::ADDR_ERROR)) begin
                resumeErr_reg <= regWdata[flash_seq_pkg::BIT_RESUME_ERR];
            end
            if (abort) begin
                resumeErr_reg <= 1'b1; // R9
            end
            if (state_reg == ST_PROT) begin
                if (isProtDis && !protVol_reg[flash_seq_pkg::BIT_ACCESS_PROT]
                    && !protVol_reg[flash_seq_pkg::BIT_DEBUG_PROT]
                    && protCycles_reg < flash_seq_pkg::PROT_CYCLE_MAX) begin // R15 R23 R16
                    protDis_reg <= protDis_reg & data0_reg[15:0];
                    if (!data0_reg[0] && protDis_reg[0]) begin
                        protCycles_reg <= protCycles_reg + flash_seq_pkg::CYCLE_STEP;
                    end
                end else if (isProtReen) begin
                    protReen_reg <= protReen_reg & data0_reg[31:16];
                end else if (!isProtDis) begin
                    protVol_reg <= data0_reg[15:0]; // R22
                end
            end
        end
    end

    // flash array writes
    always_ff @(posedge mclk) begin
        if (rst) begin
            flashWrEn <= 1'b0;
            flashWrAddr <= 24'h000000;
            flashWrData <= 32'h00000000;
        end else begin
            flashWrEn <= timerDone && (state_reg == ST_PROG_LO || state_reg == ST_PROG_HI);
            flashWrAddr <= state_reg == ST_PROG_HI ? req.addr | 24'h000004 : req.addr;
            flashWrData <= state_reg == ST_PROG_HI ? req.data[63:32] : req.data[31:0];
        end
    end

    // read side
    always_ff @(posedge mclk) begin
        if (rst) begin
            regRdata <= 16'h0000;
            busy <= 1'b0;
        end else begin
            busy <= !idle;
            regRdata <= 16'h0000;
            if (regRd) begin
                unique case (regAddr)
                    flash_seq_pkg::ADDR_CTRL0_LOW:  regRdata <= ctrl0Low_reg;
                    flash_seq_pkg::ADDR_CTRL0_HIGH: regRdata <= ctrl0High_reg;
                    flash_seq_pkg::ADDR_SECT_LOW:   regRdata <= sectSel_reg[15:0];
                    flash_seq_pkg::ADDR_SECT_HIGH:  regRdata <= sectSel_reg[31:16];
                    flash_seq_pkg::ADDR_TADDR_LOW:  regRdata <= targetAddr_reg[15:0];
                    flash_seq_pkg::ADDR_TADDR_HIGH: regRdata <= targetAddr_reg[31:16];
                    flash_seq_pkg::ADDR_DATA0_LOW:  regRdata <= data0_reg[15:0];
                    flash_seq_pkg::ADDR_DATA0_HIGH: regRdata <= data0_reg[31:16];
                    flash_seq_pkg::ADDR_DATA1_LOW:  regRdata <= data1_reg[15:0];
                    flash_seq_pkg::ADDR_DATA1_HIGH: regRdata <= data1_reg[31:16];
                    flash_seq_pkg::ADDR_ERROR:      regRdata <= {15'h0000, resumeErr_reg};
                    flash_seq_pkg::ADDR_PROT_DIS:   regRdata <= protDis_reg;
                    flash_seq_pkg::ADDR_PROT_REEN:  regRdata <= protReen_reg;
                    flash_seq_pkg::ADDR_PROT_VOL:   regRdata <= protVol_reg;
                    flash_seq_pkg::ADDR_PROT_CNT:   regRdata <= {11'h000, protCycles_reg};
                    default:                        regRdata <= {memRdData[15:0]};
                endcase
            end
        end
    end
endmodule

/* File: verif/flash_seq_assertions.sv */
`timescale 1ns/100ps
module flash_seq_assertions (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [3:0]  regAddr,
    input wire logic [15:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [15:0] regRdata,
    input wire logic        flashWrEn,
    input wire logic [23:0] flashWrAddr,
    input wire logic [31:0] flashWrData,
    input wire logic        busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic ctlWr;
    logic startWr;
    assign ctlWr = regWr && regAddr == flash_seq_pkg::ADDR_CTRL0_HIGH;
    assign startWr = ctlWr && regWdata[15];
    AST_RD_IDLE: assert property (!$past(regRd) |-> regRdata == 16'h0000)
        else $error("read data without read strobe");
    AST_START_BUSY: assert property (startWr && (regWdata[13] || regWdata[12])
        && !regWdata[14] && !busy |-> ##2 busy) else $error("program start not taken");
    AST_SUSPEND_REQUEST_START: assert property (startWr && regWdata[14] && !busy |-> ##2 !busy)
        else $error("start with suspend accepted");
    AST_NO_EARLY: assert property ($rose(busy) |-> !flashWrEn [*8])
        else $error("array written too early");
    AST_IDLE_NO_WR: assert property (!busy && !$past(busy) |-> !flashWrEn)
        else $error("array written while idle");
    AST_WORD_GAP: assert property (flashWrEn |=> !flashWrEn [*8])
        else $error("array writes too close together");
    AST_STAY_IDLE: assert property (!busy && !startWr && !$past(startWr) |=> !busy)
        else $error("busy without start");
    AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(startWr, 2))
        else $error("busy rose without start write");
    cover property ($rose(busy));
    cover property (flashWrEn ##[1:300] flashWrEn);
    cover property ($fell(busy));
endmodule
bind flash_write_operation_sequencer flash_seq_assertions flash_seq_assertions_i (
    .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .flashWrEn(flashWrEn), .flashWrAddr(flashWrAddr),
    .flashWrData(flashWrData), .busy(busy));

/* File: verif/test_flash_write_operation_sequencer.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
    $display("unexpected at %0t: %h vs %h", $time, (a), (e)); end end
module test_flash_write_operation_sequencer;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [15:0] regRdata;
    logic        flashWrEn;
    logic [23:0] flashWrAddr;
    logic [31:0] flashWrData;
    logic        busy;
    logic [15:0] v;
    int          errors = 0;
    int          cmp_count = 0;
    int          n;
    int          n0;
    int          weCount = 0;
    flash_write_operation_sequencer flash_write_operation_sequencer_i (.mclk(mclk), .rst(rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .flashWrEn(flashWrEn), .flashWrAddr(flashWrAddr),
        .flashWrData(flashWrData), .busy(busy));
    initial begin
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) weCount += int'(flashWrEn === 1'b1);
    function automatic logic [23:0] word_addr(input logic [23:0] a, input bit dw, input bit up);
        return dw ? {a[23:3], up, a[1:0]} : a;
    endfunction
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [3:0] a);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 v = regRdata;
        @(posedge mclk);
    endtask
    // wantWe: wait for an array write, else for busy to drop
    task automatic wait_for(input bit wantWe, input int lim);
        n = 0;
        do begin
            @(posedge mclk);
            #1 n++;
        end while ((wantWe ? flashWrEn !== 1'b1 : busy !== 1'b0) && n < lim);
        `CHK(n < lim, 1'b1)
    endtask
    task automatic prog(input bit dw, input bit idle);
        logic [15:0] al;
        logic [31:0] d0;
        logic [31:0] d1;
        logic [23:0] a;
        al = (16'($urandom) & 16'hfffc) | {13'h0, dw, 2'h0};
        d0 = $urandom;
        d1 = $urandom;
        a = {8'($urandom), al};
        wr(flash_seq_pkg::ADDR_CTRL0_HIGH, dw ? 16'h1080 : 16'h2080);
        wr(flash_seq_pkg::ADDR_TADDR_LOW, al);
        wr(flash_seq_pkg::ADDR_TADDR_HIGH, {8'h00, a[23:16]});
        wr(flash_seq_pkg::ADDR_DATA0_LOW, d0[15:0]);
        wr(flash_seq_pkg::ADDR_DATA0_HIGH, d0[31:16]);
        wr(flash_seq_pkg::ADDR_DATA1_LOW, d1[15:0]);
        wr(flash_seq_pkg::ADDR_DATA1_HIGH, d1[31:16]);
        wr(flash_seq_pkg::ADDR_CTRL0_HIGH, dw ? 16'h9080 : 16'ha080);
        rd(flash_seq_pkg::ADDR_CTRL0_HIGH);
        `CHK(v & 16'h4800, 16'h0000)
        wait_for(1'b1, flash_seq_pkg::PROG_CYCLES + 40);
        `CHK(n + 8 > flash_seq_pkg::PROG_CYCLES, 1'b1)
        `CHK(flashWrAddr, word_addr(a, dw, 1'b0))
        `CHK(flashWrData, d0)
        if (dw) begin
            wait_for(1'b1, flash_seq_pkg::PROG_CYCLES + 40);
            `CHK(flashWrAddr, word_addr(a, dw, 1'b1))
            `CHK(flashWrData, d1)
        end
        if (idle) begin
            wait_for(1'b0, 40);
            rd(flash_seq_pkg::ADDR_CTRL0_HIGH);
            `CHK(v, 16'h0000)
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        errors++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'hb65ed2f7));
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(flash_seq_pkg::ADDR_ERROR);
        `CHK(v, 16'h0000)
        `CHK(busy, 1'b0)
        repeat (2) prog(1'b0, 1'b1);
        prog(1'b1, 1'b1);
        $display("test program done");
        wr(flash_seq_pkg::ADDR_CTRL0_HIGH, 16'h2080);
        wr(flash_seq_pkg::ADDR_CTRL0_HIGH, 16'h0080);
        wr(flash_seq_pkg::ADDR_CTRL0_HIGH, 16'he080);
        repeat (flash_seq_pkg::PROG_CYCLES + 20) @(posedge mclk);
        `CHK(busy, 1'b0)
        $display("test cancel done");
        n0 = weCount;
        wr(flash_seq_pkg::ADDR_CTRL0_HIGH, 16'h2080);
        wr(flash_seq_pkg::ADDR_CTRL0_HIGH, 16'ha080);
        repeat (20) @(posedge mclk);
        wr(flash_seq_pkg::ADDR_CTRL0_HIGH, 16'he080);
        repeat (flash_seq_pkg::PROG_CYCLES + 20) @(posedge mclk);
        `CHK(busy, 1'b1)
        wr(flash_seq_pkg::ADDR_CTRL0_HIGH, 16'h1080);
        wr(flash_seq_pkg::ADDR_CTRL0_HIGH, 16'h9080);
        wait_for(1'b0, 40);
        `CHK(weCount, n0)
        rd(flash_seq_pkg::ADDR_ERROR);
        `CHK(v[0], 1'b1)
        $display("test suspend done");
        wr(flash_seq_pkg::ADDR_SECT_LOW, 16'h0001);
        wr(flash_seq_pkg::ADDR_SECT_HIGH, 16'h0000);
        wr(flash_seq_pkg::ADDR_CTRL0_HIGH, 16'h0880);
        wr(flash_seq_pkg::ADDR_CTRL0_HIGH, 16'h8880);
        repeat (50) @(posedge mclk);
        wr(flash_seq_pkg::ADDR_CTRL0_HIGH, 16'hc880);
        wr(flash_seq_pkg::ADDR_CTRL0_HIGH, 16'h0080);
        prog(1'b0, 1'b0);
        wr(flash_seq_pkg::ADDR_CTRL0_HIGH, 16'h0880);
        wr(flash_seq_pkg::ADDR_CTRL0_HIGH, 16'h8880);
        wait_for(1'b0, flash_seq_pkg::ERASE_CYCLES + 100);
        rd(flash_seq_pkg::ADDR_SECT_LOW);
        `CHK(v, 16'h0000)
        rd(flash_seq_pkg::ADDR_SECT_HIGH);
        `CHK(v, 16'h0000)
        $display("test erase done");
        wr(flash_seq_pkg::ADDR_CTRL0_HIGH, 16'h0100);
        wr(flash_seq_pkg::ADDR_TADDR_LOW, flash_seq_pkg::PROT_DIS_ADDR_LOW);
        wr(flash_seq_pkg::ADDR_TADDR_HIGH, flash_seq_pkg::PROT_ADDR_HIGH);
        wr(flash_seq_pkg::ADDR_DATA0_LOW, 16'hfffe);
        wr(flash_seq_pkg::ADDR_CTRL0_HIGH, 16'h8100);
        wait_for(1'b0, flash_seq_pkg::PROG_CYCLES + 40);
        rd(flash_seq_pkg::ADDR_PROT_DIS);
        `CHK(v, 16'hffff)
        rd(flash_seq_pkg::ADDR_PROT_CNT);
        `CHK(v, 16'h0000)
        $display("test protection done");
        wrap_up();
    end
endmodule
